/* design/fsib_flash.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsib_defines.svh"
module fsib_flash
    import fsib_pkg::*;
#(
    parameter int ROW_W = 9,
    parameter logic [31:0] UNSEAL_KEYS = 32'h5a3c_c3a5,
    parameter logic [31:0] FULL_KEYS = 32'hffff_ffff
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ROW_W+4:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic wr_en,
    input wire logic [ROW_W+4:0] wr_addr,
    input wire logic [7:0] wr_data,
    output fsib_keys_t unseal_keys,
    output fsib_keys_t full_keys
);
    localparam logic [63:0] KEY_INIT = {FULL_KEYS, UNSEAL_KEYS};
    localparam logic [9:0] KEY_FULL = {`FSIB_KEY_SUBCLASS, 2'b00}; // Same fold as the access row
    localparam logic [ROW_W-1:0] KEY_TAG = KEY_FULL[ROW_W-1:0];

    logic [7:0] mem [2**(ROW_W+5)];
    logic [7:0] key_byte [`FSIB_KEY_BYTES];
    logic [7:0] next_key_byte [`FSIB_KEY_BYTES];
    logic wr_key;
    logic rd_key;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // Bulk array has no reset: it stands for nonvolatile cells
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Key bytes come up with their defaults, else nothing could unseal
    assign wr_key = wr_en && wr_addr[ROW_W+4:5] == KEY_TAG[ROW_W-1:0] && wr_addr[4:3] == 2'b00;
    assign rd_key = rd_addr[ROW_W+4:5] == KEY_TAG[ROW_W-1:0] && rd_addr[4:3] == 2'b00;

    always_comb
    begin
        for (int i = 0; i < `FSIB_KEY_BYTES; i++)
        begin
            next_key_byte[i] = key_byte[i];
        end
        if (wr_key)
        begin
            next_key_byte[wr_addr[2:0]] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < `FSIB_KEY_BYTES; i++)
            begin
                key_byte[i] <= KEY_INIT[8*i +: 8];
            end
        end
        else
        begin
            key_byte <= next_key_byte;
        end
    end

    // ----------------------------------------------------------------
    // Read side
    // ----------------------------------------------------------------
    assign rd_data = rd_key ? key_byte[rd_addr[2:0]] : mem[rd_addr];
    assign unseal_keys = {key_byte[3], key_byte[2], key_byte[1], key_byte[0]};
    assign full_keys = {key_byte[7], key_byte[6], key_byte[5], key_byte[4]};
endmodule : fsib_flash
`default_nettype wire

/* design/fsib_flash_access.sv */
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fsib_defines.svh"
// Summary of operation
// - Ninety-six bytes of info storage, three 32-byte blocks A, B and C.
// - Open_level with general access, class then block select fill the window.
// - Commit the window to flash only after a correct checksum arrives.
// - Info block B lives at subclass 58, offsets 32 to 63.
// - Sealed or info access, block select 1, 2, 3 loads block A, B, C.
// - Correct checksum on a selected info block writes it back.
// - Info block A cannot be modified while sealed.
// - Three levels; sealed blocks user flash, info blocks always readable.
// - Key storage is writable only at full access.
// - Key pairs arrive as two consecutive control writes; others void them.
// - Sealed flag set while sealed, cleared by the correct unseal pair.
// - Full-access flag cleared by the correct full-access pair.
// - Two 16-bit key words per set, separate unseal and full-access sets.
// - Key 1 first, then key 0, each byte swapped against readback.
// - Checksum is 255 minus low byte of window sum, at location 0x60.
// - Access control 0 means general flash, 1 means info block selection.
// - Window occupies locations 0x40 to 0x5f, 32 bytes.
// - Level changes are commanded through the control word at 0x00.
module fsib_flash_access
    import fsib_pkg::*;
#(
    parameter int ROW_W = 9,
    parameter logic [31:0] UNSEAL_KEYS = 32'h5a3c_c3a5,
    parameter logic [31:0] FULL_KEYS = 32'hffff_ffff
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    fsib_state_t state, next_state;
    fsib_level_t level, next_level;
    logic [7:0] window [`FSIB_WINDOW_BYTES];
    logic [7:0] next_window [`FSIB_WINDOW_BYTES];
    logic [7:0] flash_class_select, next_flash_class_select;
    logic [7:0] flash_block_select, next_flash_block_select;
    logic [7:0] block_checksum, next_block_checksum;
    logic [7:0] block_access_control, next_block_access_control;
    logic [ROW_W-1:0] row, next_row;
    logic row_valid, next_row_valid;
    logic [4:0] cnt, next_cnt;
    logic key_armed, next_key_armed;
    logic [15:0] key_prev, next_key_prev;
    logic [31:0] next_readdata;
    logic next_waitrequest;

    // Flash port and helpers
    logic flash_wr_en;
    logic [7:0] flash_rd_data;
    fsib_keys_t unseal_keys;
    fsib_keys_t full_keys;
    logic [7:0] window_sum;
    logic info_mode;
    logic commit_ok;
    logic [15:0] status_word;
    logic [15:0] ctl;
    logic [7:0] wbyte;
    logic take;

    // Subclass and block fold into one flash row
    function automatic logic [ROW_W-1:0] row_of(input logic [7:0] sc, input logic [7:0] blk);
        logic [9:0] full_row;
        full_row = {sc, blk[1:0]};
        return full_row[ROW_W-1:0];
    endfunction : row_of

    localparam logic [ROW_W-1:0] KEY_ROW = row_of(`FSIB_KEY_SUBCLASS, 8'h00);

    // ----------------------------------------------------------------
    // Flash array
    // ----------------------------------------------------------------
    fsib_flash #(
        .ROW_W(ROW_W),
        .UNSEAL_KEYS(UNSEAL_KEYS),
        .FULL_KEYS(FULL_KEYS)
    ) u_flash (
        .clk(clk),
        .resetn(resetn),
        .rd_addr({row, cnt}),
        .rd_data(flash_rd_data),
        .wr_en(flash_wr_en),
        .wr_addr({row, cnt}),
        .wr_data(window[cnt]),
        .unseal_keys(unseal_keys),
        .full_keys(full_keys)
    );

    // ----------------------------------------------------------------
    // Derived terms
    // ----------------------------------------------------------------
    // Window sum, eight bits, wraps as the host computes it
    always_comb
    begin
        window_sum = 8'h00;
        for (int i = 0; i < `FSIB_WINDOW_BYTES; i++)
        begin
            window_sum = window_sum + window[i];
        end
    end

    // Sealed always forces info block selection
    assign info_mode = level == sealed_level || block_access_control != `FSIB_ACCESS_GENERAL;

    // Who may commit the loaded row
    always_comb
    begin
        if (!row_valid)
        begin
            commit_ok = 1'b0;
        end
        else if (info_mode)
        begin
            commit_ok = !(level == sealed_level && flash_block_select == `FSIB_INFO_A);
        end
        else
        begin
            commit_ok = level != sealed_level && (row != KEY_ROW || level == full_level);
        end
    end

    // Sealed flag is one while sealed, full-access flag is one until full access is reached
    always_comb
    begin
        status_word = 16'h0000;
        status_word[`FSIB_SS_BIT] = level == sealed_level;
        status_word[`FSIB_FULL_BIT] = level != full_level;
    end

    assign ctl = avs_writedata[15:0];
    assign wbyte = avs_writedata[7:0];
    assign take = (avs_read || avs_write) && avs_waitrequest && state == st_idle;
    assign flash_wr_en = state == st_store;

    // ----------------------------------------------------------------
    // Bus slave, key sequencer and block engine
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_level = level;
        next_window = window;
        next_flash_class_select = flash_class_select;
        next_flash_block_select = flash_block_select;
        next_block_checksum = block_checksum;
        next_block_access_control = block_access_control;
        next_row = row;
        next_row_valid = row_valid;
        next_cnt = cnt;
        next_key_armed = key_armed;
        next_key_prev = key_prev;
        next_readdata = avs_readdata;
        next_waitrequest = 1'b1;
        case (state)
            st_idle:
            begin
                if (take && avs_read)
                begin
                    next_waitrequest = 1'b0;
                    next_readdata = `FSIB_RST_DATA;
                    if (avs_address == `FSIB_LOC_CONTROL)
                    begin
                        next_readdata[15:0] = status_word;
                    end
                    else if (avs_address == `FSIB_LOC_CLASS && level != sealed_level)
                    begin
                        next_readdata[7:0] = flash_class_select;
                    end
                    else if (avs_address == `FSIB_LOC_BLOCK)
                    begin
                        next_readdata[7:0] = flash_block_select;
                    end
                    else if (avs_address >= `FSIB_LOC_WINDOW && avs_address <= `FSIB_LOC_WINDOW_END)
                    begin
                        next_readdata[7:0] = window[avs_address[4:0]];
                    end
                    else if (avs_address == `FSIB_LOC_CHECKSUM)
                    begin
                        next_readdata[7:0] = block_checksum;
                    end
                    else if (avs_address == `FSIB_LOC_ACCESS && level != sealed_level)
                    begin
                        next_readdata[7:0] = block_access_control;
                    end
                end
                else if (take && avs_write)
                begin
                    next_waitrequest = 1'b0;
                    if (!avs_byteenable[0])
                    begin
                        next_waitrequest = 1'b0;
                    end
                    else if (avs_address == `FSIB_LOC_CONTROL)
                    begin
                        // Any control write replaces the held first key
                        next_key_armed = 1'b1;
                        next_key_prev = ctl;
                        if (key_armed && key_prev == fsib_swap(unseal_keys.key1)
                            && ctl == fsib_swap(unseal_keys.key0) && level == sealed_level)
                        begin
                            next_level = open_level;
                            next_key_armed = 1'b0;
                        end
                        else if (key_armed && key_prev == fsib_swap(full_keys.key1)
                            && ctl == fsib_swap(full_keys.key0) && level == open_level)
                        begin
                            next_level = full_level;
                            next_key_armed = 1'b0;
                        end
                        else if (ctl == `FSIB_CMD_SEAL)
                        begin
                            next_level = sealed_level;
                            next_row_valid = 1'b0;
                        end
                    end
                    else if (avs_address == `FSIB_LOC_CLASS)
                    begin
                        if (level != sealed_level)
                        begin
                            next_flash_class_select = wbyte;
                        end
                    end
                    else if (avs_address == `FSIB_LOC_BLOCK)
                    begin
                        next_flash_block_select = wbyte;
                        next_row_valid = 1'b0;
                        if (!info_mode)
                        begin
                            next_row = row_of(flash_class_select, wbyte);
                            next_row_valid = 1'b1;
                        end
                        else if (wbyte >= `FSIB_INFO_A && wbyte <= `FSIB_INFO_C)
                        begin
                            // A, B, C are blocks 0..2 of the info subclass
                            next_row = row_of(`FSIB_INFO_SUBCLASS, wbyte - 8'h01);
                            next_row_valid = 1'b1;
                        end
                        if (next_row_valid)
                        begin
                            // Bus stays stalled until the copy is done
                            next_waitrequest = 1'b1;
                            next_cnt = 5'd0;
                            next_state = st_load;
                        end
                    end
                    else if (avs_address >= `FSIB_LOC_WINDOW && avs_address <= `FSIB_LOC_WINDOW_END)
                    begin
                        next_window[avs_address[4:0]] = wbyte;
                    end
                    else if (avs_address == `FSIB_LOC_CHECKSUM)
                    begin
                        next_block_checksum = wbyte;
                        // Mismatch answers at once and keeps the window
                        if (commit_ok && wbyte == ~window_sum)
                        begin
                            next_waitrequest = 1'b1;
                            next_cnt = 5'd0;
                            next_state = st_store;
                        end
                    end
                    else if (avs_address == `FSIB_LOC_ACCESS)
                    begin
                        if (level != sealed_level)
                        begin
                            next_block_access_control = wbyte;
                            next_row_valid = 1'b0;
                        end
                    end
                end
            end
            st_load:
            begin
                next_window[cnt] = flash_rd_data;
                next_cnt = cnt + 5'd1;
                if (cnt == 5'd31)
                begin
                    next_state = st_idle;
                    next_waitrequest = 1'b0;
                end
            end
            st_store:
            begin
                // One byte per cycle into the selected row
                next_cnt = cnt + 5'd1;
                if (cnt == 5'd31)
                begin
                    next_state = st_idle;
                    next_waitrequest = 1'b0;
                end
            end
            default:
            begin
                next_state = st_idle;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= st_idle;
            level <= sealed_level;
            for (int i = 0; i < `FSIB_WINDOW_BYTES; i++)
            begin
                window[i] <= `FSIB_RST_BYTE;
            end
            flash_class_select <= `FSIB_RST_BYTE;
            flash_block_select <= `FSIB_RST_BYTE;
            block_checksum <= `FSIB_RST_BYTE;
            block_access_control <= `FSIB_RST_BYTE;
            row <= '0;
            row_valid <= 1'b0;
            cnt <= 5'd0;
            key_armed <= 1'b0;
            key_prev <= `FSIB_RST_WORD;
            avs_readdata <= `FSIB_RST_DATA;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            state <= next_state;
            level <= next_level;
            window <= next_window;
            flash_class_select <= next_flash_class_select;
            flash_block_select <= next_flash_block_select;
            block_checksum <= next_block_checksum;
            block_access_control <= next_block_access_control;
            row <= next_row;
            row_valid <= next_row_valid;
            cnt <= next_cnt;
            key_armed <= next_key_armed;
            key_prev <= next_key_prev;
            avs_readdata <= next_readdata;
            avs_waitrequest <= next_waitrequest;
        end
    end
endmodule : fsib_flash_access
`default_nettype wire

/* inc/fsib_defines.svh */
`ifndef FSIB_DEFINES_SVH
`define FSIB_DEFINES_SVH
// ----------------------------------------------------------------
// Command locations, as word indices on the register bus
// ----------------------------------------------------------------
`define FSIB_LOC_CONTROL 7'h00
`define FSIB_LOC_CLASS 7'h3e
`define FSIB_LOC_BLOCK 7'h3f
`define FSIB_LOC_WINDOW 7'h40
`define FSIB_LOC_WINDOW_END 7'h5f
`define FSIB_LOC_CHECKSUM 7'h60
`define FSIB_LOC_ACCESS 7'h61
// ----------------------------------------------------------------
// Flash layout
// ----------------------------------------------------------------
`define FSIB_WINDOW_BYTES 32
`define FSIB_INFO_SUBCLASS 8'h3a
`define FSIB_KEY_SUBCLASS 8'h70
`define FSIB_KEY_BYTES 8
`define FSIB_INFO_A 8'h01
`define FSIB_INFO_C 8'h03
`define FSIB_ACCESS_GENERAL 8'h00
// ----------------------------------------------------------------
// Control status word and subcommands
// ----------------------------------------------------------------
`define FSIB_SS_BIT 13
`define FSIB_FULL_BIT 14
`define FSIB_CMD_SEAL 16'h0020
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FSIB_RST_BYTE 8'h00
`define FSIB_RST_WORD 16'h0000
`define FSIB_RST_DATA 32'h0000_0000
`endif

/* inc/fsib_pkg.sv */
package fsib_pkg;
    // Security level
    typedef enum logic [1:0]
    {
        sealed_level = 2'b00,
        open_level = 2'b01,
        full_level = 2'b10
    } fsib_level_t;

    // Access sequencer
    typedef enum logic [1:0]
    {
        st_idle = 2'b00,
        st_load = 2'b01,
        st_store = 2'b10
    } fsib_state_t;

    // One key set as it reads back
    typedef struct packed
    {
        logic [15:0] key1;
        logic [15:0] key0;
    } fsib_keys_t;

    // Keys travel byte swapped on the control word
    function automatic logic [15:0] fsib_swap(input logic [15:0] w);
        return {w[7:0], w[15:8]};
    endfunction : fsib_swap
endpackage : fsib_pkg

/* test/fsib_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ------
// Host side of the register bus
// ------
module fsib_host (
    input wire logic clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [6:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    // Idle bus from time zero
    initial
    begin
        avs_address = 7'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
    end

    // One transfer, held until waitrequest is seen low; only the watchdog ends a hang
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= d;
        avs_byteenable <= be;
        do
            @(posedge clk);
        while (avs_waitrequest);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : xfer
endmodule : fsib_host
`default_nettype wire

/* test/fsib_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsib_defines.svh"
// ------
// Port checker
// ------
module fsib_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    logic sealed, next_sealed;
    logic rd_ack, ctl_wr;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    assign rd_ack = avs_read && !avs_waitrequest;
    assign ctl_wr = avs_write && !avs_waitrequest && avs_address == `FSIB_LOC_CONTROL
        && avs_byteenable[0];

    // Sure-sealed tracker; any other control word drops it, so it never over-claims
    always_comb
    begin
        next_sealed = sealed;
        if (ctl_wr)
            next_sealed = avs_writedata[15:0] == `FSIB_CMD_SEAL;
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sealed <= 1'b1;
        else
            sealed <= next_sealed;
    end

    sequence s_take_blk;
        $rose(avs_write) && avs_address == `FSIB_LOC_BLOCK && sealed && avs_byteenable[0]
            && avs_writedata[7:0] inside {[8'h01:8'h03]};
    endsequence
    sequence s_load_done;
        ##32 avs_waitrequest ##1 !avs_waitrequest;
    endsequence

    a_block_load: assert property (s_take_blk |-> s_load_done)
        else $error("info block load span wrong");
    a_win_ack: assert property ($rose(avs_write) && avs_address >= `FSIB_LOC_WINDOW
        && avs_address <= `FSIB_LOC_WINDOW_END |=> !avs_waitrequest)
        else $error("window write not answered next cycle");
    a_ctl_ack: assert property ($rose(avs_write) && avs_address == `FSIB_LOC_CONTROL
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("control write answer wrong");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_idle_wait: assert property (!avs_read && !avs_write |-> avs_waitrequest)
        else $error("answer without request");
    a_seal_status: assert property (rd_ack && avs_address == `FSIB_LOC_CONTROL && sealed
        |-> avs_readdata[`FSIB_SS_BIT] && avs_readdata[`FSIB_FULL_BIT])
        else $error("sealed status flags wrong");
    a_sealed_hidden: assert property (rd_ack && sealed && (avs_address == `FSIB_LOC_CLASS
        || avs_address == `FSIB_LOC_ACCESS) |-> avs_readdata == 32'h0000_0000)
        else $error("selector visible while sealed");
    a_unmapped_zero: assert property (rd_ack && avs_address > `FSIB_LOC_ACCESS
        |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property ($changed(avs_readdata) |-> rd_ack)
        else $error("read data moved outside a read");
endmodule : fsib_monitor
bind fsib_flash_access fsib_monitor mon (.clk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
`default_nettype wire

/* test/tb_flash_security_and_info_blocks.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsib_defines.svh"
// ------
// Bench top
// ------
module tb_flash_security_and_info_blocks;
    logic clk;
    logic resetn;
    logic [6:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int error_cnt;
    int checks;
    int seed;
    logic [7:0] win [32];
    logic [7:0] img_a [32];
    logic [7:0] img_b [32];
    logic [7:0] img_g [32];
    logic [31:0] q;
    logic [31:0] nk;
    logic [7:0] c;
    logic [7:0] b;

    fsib_flash_access #(.ROW_W(9)) uut (.clk, .resetn, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
    fsib_host host (.clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable);

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] sw(input logic [15:0] w);
        return {16'h0000, w[7:0], w[15:8]};
    endfunction : sw
    // Expected checksum of the window image
    function automatic logic [7:0] csum();
        logic [7:0] s;
        s = 8'h00;
        foreach (win[i]) s += win[i];
        return ~s;
    endfunction : csum
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        host.xfer(1'b0, a, d, 4'hf, q);
    endtask : wr
    task automatic rd(input logic [6:0] a);
        host.xfer(1'b1, a, 32'h0000_0000, 4'hf, q);
    endtask : rd
    task automatic st(input logic [1:0] e);
        rd(`FSIB_LOC_CONTROL);
        chk("status", 32'(e), 32'(q[14:13]));
    endtask : st
    task automatic keys(input logic [31:0] k);
        wr(`FSIB_LOC_CONTROL, sw(k[31:16]));
        wr(`FSIB_LOC_CONTROL, sw(k[15:0]));
    endtask : keys
    task automatic sel(input logic [7:0] acc, input logic [7:0] cl, input logic [7:0] bl);
        wr(`FSIB_LOC_ACCESS, 32'(acc));
        wr(`FSIB_LOC_CLASS, 32'(cl));
        wr(`FSIB_LOC_BLOCK, 32'(bl));
    endtask : sel
    // Window fill; a wrong checksum is one bit off so it stays near the real one
    task automatic fill(input bit good, input bit rnd);
        for (int i = 0; i < 32; i++)
        begin
            if (rnd)
                win[i] = 8'($random(seed));
            wr(`FSIB_LOC_WINDOW + 7'(i), 32'(win[i]));
        end
        wr(`FSIB_LOC_CHECKSUM, 32'(csum() ^ 8'(!good)));
    endtask : fill
    task automatic cmp(input string nm, input logic [7:0] e [32]);
        for (int i = 0; i < 32; i++)
        begin
            rd(`FSIB_LOC_WINDOW + 7'(i));
            chk(nm, 32'(e[i]), q);
        end
    endtask : cmp
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // Watchdog well past the few thousand cycles the sequence needs
    initial
    begin
        repeat (50000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    // Main sequence
    initial
    begin
        seed = 32'h0000_cf9a;
        error_cnt = 0;
        checks = 0;
        resetn = 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        st(2'b11);
        wr(`FSIB_LOC_CLASS, 32'h0000_0055);
        rd(`FSIB_LOC_CLASS);
        chk("sealed class", 32'h0000_0000, q);
        wr(`FSIB_LOC_CONTROL, sw(16'h5a3c));
        wr(`FSIB_LOC_CONTROL, 32'h0000_0001);
        wr(`FSIB_LOC_CONTROL, sw(16'hc3a5));
        st(2'b11);
        keys(32'($random(seed)) | 32'h8080_8080);
        st(2'b11);
        keys(32'hffff_ffff);
        st(2'b11);
        keys(32'h5a3c_c3a5);
        st(2'b10);
        $display("key sequence test done");
        c = 8'h10 + 8'($random(seed) & 32'h0000_001f);
        b = 8'($random(seed) & 32'h0000_0003);
        sel(8'h00, c, b);
        fill(1'b1, 1'b1);
        img_g = win;
        sel(8'h00, c + 8'h01, b);
        sel(8'h00, c, b);
        cmp("general", img_g);
        fill(1'b0, 1'b1);
        host.xfer(1'b0, `FSIB_LOC_WINDOW, 32'(~win[0]), 4'he, q);
        rd(`FSIB_LOC_WINDOW);
        chk("kept window", 32'(win[0]), q);
        sel(8'h00, c, b);
        cmp("bad sum", img_g);
        sel(8'h01, 8'h00, 8'h02);
        fill(1'b1, 1'b1);
        img_b = win;
        sel(8'h00, `FSIB_INFO_SUBCLASS, 8'h01);
        cmp("info b", img_b);
        sel(8'h01, 8'h00, `FSIB_INFO_A);
        fill(1'b1, 1'b1);
        img_a = win;
        $display("flash access test done");
        keys(32'hffff_ffff);
        st(2'b00);
        nk = 32'($random(seed)) | 32'h8080_8080;
        sel(8'h00, `FSIB_KEY_SUBCLASS, 8'h00);
        win = '{default: 8'hff};
        {win[3], win[2], win[1], win[0]} = {nk[31:16], nk[15:0]};
        fill(1'b1, 1'b0);
        wr(`FSIB_LOC_CONTROL, 32'(`FSIB_CMD_SEAL));
        st(2'b11);
        sel(8'h01, 8'h00, `FSIB_INFO_A);
        cmp("info a", img_a);
        fill(1'b1, 1'b1);
        sel(8'h01, 8'h00, `FSIB_INFO_A);
        cmp("locked a", img_a);
        sel(8'h01, 8'h00, `FSIB_INFO_C);
        fill(1'b1, 1'b1);
        sel(8'h01, 8'h00, 8'h02);
        cmp("sealed b", img_b);
        sel(8'h01, 8'h00, `FSIB_INFO_C);
        cmp("info c", win);
        $display("sealed info test done");
        keys(32'h5a3c_c3a5);
        st(2'b11);
        keys(nk);
        st(2'b10);
        rd(7'h70);
        chk("unmapped", 32'h0000_0000, q);
        $display("key update test done");
        summarize();
    end
endmodule : tb_flash_security_and_info_blocks
`default_nettype wire
